//--- common/ccs_pkg.sv
// Constants and types for the carrier and collision sense path
package ccs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_TIME_NS = 100;
  // Carrier holds 1.5 bit times past the end of the last bit
  localparam int CRS_TAIL_NS = 150;
  // The last line transition sits mid-bit, so half a bit is added
  localparam int CRS_HOLD_NS = BIT_TIME_NS / 2 + CRS_TAIL_NS;
  localparam logic [3:0] CRS_HOLD_CYC = 4'((CRS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Collision signal from the transceiver runs at 10 MHz
  localparam int COL_PERIOD_NS = 100;
  localparam int COL_HOLD_NS = 2 * COL_PERIOD_NS;
  localparam logic [3:0] COL_HOLD_CYC = 4'(COL_HOLD_NS / CLK_PERIOD_NS);
  // Window after a transmission in which the heartbeat is expected
  localparam int HB_WINDOW_NS = 4000;
  localparam logic [7:0] HB_WINDOW_CYC = 8'(HB_WINDOW_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam int SYNC_W = 6;
  // Select stage resets to external so the shared pins stay undriven until the strap is known
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h20;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] HB_CNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FRAME = 2'h1,
    ST_HBEAT = 2'h3
  } ccs_state_t;

  typedef struct packed {
    logic carrier;
    logic collision;
  } ccs_sense_t;

  localparam ccs_sense_t SENSE_RST = 2'h0;

endpackage

//--- core/ccs_sense.sv
// Carrier sense and collision path between line codec and media access unit
`timescale 1ns/100ps
`default_nettype none

module ccs_sense (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic codec_source_select_i,
  input wire logic rx_line_i,
  input wire logic collision_pair_pos_i,
  input wire logic collision_pair_neg_i,
  input wire logic carrier_sense_in_i,
  input wire logic collision_in_i,
  input wire logic tx_sfd_start_i,
  input wire logic tx_active_i,
  output logic carrier_sense_out_o,
  output logic carrier_sense_oe_o,
  output logic collision_out_o,
  output logic collision_oe_o,
  output logic mac_carrier_sense_o,
  output logic mac_collision_o,
  output logic tx_collision_o,
  output logic heartbeat_seen_o,
  output logic heartbeat_missing_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bit order: 5 select, 4 rx line, 3 pair pos, 2 pair neg, 1 crs in, 0 col in
  logic [ccs_pkg::SYNC_W-1:0] pin_raw;
  logic [ccs_pkg::SYNC_W-1:0] sync_meta;
  logic [ccs_pkg::SYNC_W-1:0] sync_q;

  assign pin_raw = {codec_source_select_i, rx_line_i, collision_pair_pos_i,
                    collision_pair_neg_i, carrier_sense_in_i, collision_in_i};

  genvar gi;
  generate
    for (gi = 0; gi < ccs_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sync_meta[gi] <= ccs_pkg::SYNC_RST[gi];
          sync_q[gi] <= ccs_pkg::SYNC_RST[gi];
        end else begin
          sync_meta[gi] <= pin_raw[gi];
          sync_q[gi] <= sync_meta[gi];
        end
      end
    end
  endgenerate

  wire ext_sel = sync_q[5];
  wire rx_line = sync_q[4];
  wire pair_diff = sync_q[3] & ~sync_q[2];
  wire ext_crs = sync_q[1];
  wire ext_col = sync_q[0];

  // ----------------------------------------------------------------
  // On-chip codec carrier and collision
  // ----------------------------------------------------------------
  logic rx_line_d;
  logic pair_diff_d;
  logic [3:0] crs_cnt;
  logic [3:0] col_cnt;

  wire rx_edge = rx_line ^ rx_line_d;
  // Only a falling transition may start carrier; a glitch high is not a frame
  wire rx_fall = rx_line_d & ~rx_line;
  wire pair_edge = pair_diff ^ pair_diff_d;
  wire [3:0] next_crs_cnt = (crs_cnt == ccs_pkg::CNT_RST) ?
                            (rx_fall ? ccs_pkg::CRS_HOLD_CYC : ccs_pkg::CNT_RST) :
                            (rx_edge ? ccs_pkg::CRS_HOLD_CYC : crs_cnt - 4'h1);
  wire [3:0] next_col_cnt = pair_edge ? ccs_pkg::COL_HOLD_CYC :
                            (col_cnt == ccs_pkg::CNT_RST) ? ccs_pkg::CNT_RST : col_cnt - 4'h1;

  ccs_pkg::ccs_sense_t int_sense;
  ccs_pkg::ccs_sense_t ext_sense;
  ccs_pkg::ccs_sense_t sel_sense;

  assign int_sense.carrier = (crs_cnt != ccs_pkg::CNT_RST);
  assign int_sense.collision = (col_cnt != ccs_pkg::CNT_RST);
  assign ext_sense.carrier = ext_crs;
  assign ext_sense.collision = ext_col;
  assign sel_sense = ext_sel ? ext_sense : int_sense;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_line_d <= 1'b0;
      pair_diff_d <= 1'b0;
      crs_cnt <= ccs_pkg::CNT_RST;
      col_cnt <= ccs_pkg::CNT_RST;
    end else begin
      rx_line_d <= rx_line;
      pair_diff_d <= pair_diff;
      crs_cnt <= next_crs_cnt;
      col_cnt <= next_col_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to pins and to the media access unit
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      carrier_sense_out_o <= 1'b0;
      collision_out_o <= 1'b0;
      carrier_sense_oe_o <= 1'b0;
      collision_oe_o <= 1'b0;
      mac_carrier_sense_o <= 1'b0;
      mac_collision_o <= 1'b0;
    end else begin
      carrier_sense_out_o <= int_sense.carrier;
      collision_out_o <= int_sense.collision;
      // Shared pins turn round to inputs when the external codec owns them
      carrier_sense_oe_o <= ~ext_sel;
      collision_oe_o <= ~ext_sel;
      mac_carrier_sense_o <= sel_sense.carrier;
      mac_collision_o <= sel_sense.collision;
    end
  end

  // ----------------------------------------------------------------
  // Transmit collision watch and heartbeat check
  // ----------------------------------------------------------------
  ccs_pkg::ccs_state_t state;
  ccs_pkg::ccs_state_t next_state;
  logic [7:0] hb_cnt;

  wire in_frame = (state == ccs_pkg::ST_FRAME);
  wire in_hbeat = (state == ccs_pkg::ST_HBEAT);
  wire hb_last = in_hbeat & (hb_cnt == 8'h01);
  wire frame_col = in_frame & sel_sense.collision;
  wire hb_hit = in_hbeat & sel_sense.collision;
  wire frame_start = (state == ccs_pkg::ST_IDLE) & tx_sfd_start_i;
  wire frame_end = in_frame & ~tx_active_i;
  wire [7:0] next_hb_cnt = frame_end ? ccs_pkg::HB_WINDOW_CYC :
                           in_hbeat ? hb_cnt - 8'h01 : ccs_pkg::HB_CNT_RST;
  // Set needs ST_FRAME or ST_HBEAT and clear needs ST_IDLE, so the two never meet; a collision in the clearing cycle is dropped
  wire next_tx_col = frame_col | (tx_collision_o & ~frame_start);
  wire next_hb_seen = hb_hit | (heartbeat_seen_o & ~frame_start);
  wire next_hb_miss = hb_last & ~heartbeat_seen_o & ~sel_sense.collision;

  always_comb begin
    next_state = state;
    case (state)
      ccs_pkg::ST_IDLE: begin
        if (tx_sfd_start_i) begin
          next_state = ccs_pkg::ST_FRAME;
        end
      end
      ccs_pkg::ST_FRAME: begin
        if (!tx_active_i) begin
          next_state = ccs_pkg::ST_HBEAT;
        end
      end
      ccs_pkg::ST_HBEAT: begin
        if (hb_last) begin
          next_state = ccs_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = ccs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ccs_pkg::ST_IDLE;
      hb_cnt <= ccs_pkg::HB_CNT_RST;
      tx_collision_o <= 1'b0;
      heartbeat_seen_o <= 1'b0;
      heartbeat_missing_o <= 1'b0;
    end else begin
      state <= next_state;
      hb_cnt <= next_hb_cnt;
      tx_collision_o <= next_tx_col;
      heartbeat_seen_o <= next_hb_seen;
      heartbeat_missing_o <= next_hb_miss;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence quiet_line_s;
    rx_edge && (int_sense.carrier || rx_fall) ##1 !rx_edge [*8];
  endsequence

  sequence frame_done_s;
    in_frame && !tx_active_i ##1 in_hbeat;
  endsequence

  crs_start_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !int_sense.carrier && rx_fall |=> int_sense.carrier ##1 mac_carrier_sense_o || ext_sel)
    else $error("carrier did not start on falling transition");

  crs_tail_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    quiet_line_s |=> !int_sense.carrier && $past(int_sense.carrier))
    else $error("carrier tail length wrong");

  crs_pin_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ##1 carrier_sense_out_o == $past(int_sense.carrier) && carrier_sense_oe_o == !$past(ext_sel))
    else $error("carrier pin does not mirror on-chip carrier");

  col_detect_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    pair_edge |=> int_sense.collision [*8] ##1 collision_out_o)
    else $error("collision not held after pair activity");

  frame_col_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    in_frame && sel_sense.collision |=> tx_collision_o)
    else $error("collision during frame not flagged");

  hb_seen_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    frame_done_s ##[0:159] hb_hit |=> heartbeat_seen_o)
    else $error("heartbeat not recorded");

  hb_miss_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    frame_done_s ##159 (!heartbeat_seen_o && !sel_sense.collision) |=> heartbeat_missing_o)
    else $error("missing heartbeat not reported");

  ext_route_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ext_sel && $stable(ext_sel) |=> mac_collision_o == $past(ext_col) && !collision_oe_o)
    else $error("external collision not routed");

  sync_path_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ##2 ext_crs == $past(carrier_sense_in_i, 2))
    else $error("carrier input not passed through two stages");

endmodule

`default_nettype wire

//--- verification/ccs_far_end.sv
// Far-side model: transceiver line and collision pair, external codec levels
`timescale 1ns/100ps
`default_nettype none
module ccs_far_end (
  input wire logic core_clk_i,
  output logic rx_line_o,
  output logic pair_pos_o,
  output logic pair_neg_o,
  output ccs_pkg::ccs_sense_t ext_o
);
  initial begin
    rx_line_o = 1'b1;
    pair_pos_o = 1'b0;
    pair_neg_o = 1'b1;
    ext_o = ccs_pkg::SENSE_RST;
  end
  // ----------------------------------------------------------------
  // Line activity
  // ----------------------------------------------------------------
  // One transition per half bit, as Manchester data would give
  task automatic rx_burst(input int n);
    repeat (n) begin
      repeat (2) @(posedge core_clk_i);
      #2 rx_line_o = ~rx_line_o;
    end
  endtask
  // 10 MHz pair signal; an even count leaves the pair idle again
  task automatic pair_burst(input int n);
    repeat (n) begin
      repeat (2) @(posedge core_clk_i);
      #2 pair_pos_o = ~pair_pos_o;
      pair_neg_o = ~pair_neg_o;
    end
  endtask
  // External codec carrier and collision are plain levels
  task automatic ext_set(input ccs_pkg::ccs_sense_t v);
    @(posedge core_clk_i);
    #2 ext_o = v;
  endtask
endmodule
`default_nettype wire

//--- verification/ccs_sense_tb.sv
// Self-checking bench for the carrier and collision sense path
`timescale 1ns/100ps
`default_nettype none
module ccs_sense_tb;
  typedef struct packed {
    logic sel;
    ccs_pkg::ccs_sense_t codec_source_select;
    ccs_pkg::ccs_sense_t mac;
    logic oe;
  } ccs_row_t;
  logic core_clk = 1'b0;
  logic arst_n;
  logic sel;
  logic sfd;
  logic tx_act;
  logic rx_line, pair_pos, pair_neg;
  ccs_pkg::ccs_sense_t codec_source_select;
  logic crs_pin, crs_oe, col_pin, col_oe, mac_crs, mac_col, tx_col, hb_seen, hb_miss;
  int errors = 0;
  int samples_checked = 0;
  ccs_row_t rows [4] = '{'{1'b0, 2'h3, 2'h0, 1'b1}, '{1'b1, 2'h2, 2'h2, 1'b0},
                         '{1'b1, 2'h1, 2'h1, 1'b0}, '{1'b1, 2'h3, 2'h3, 1'b0}};
  always #12.5 core_clk = ~core_clk;
  ccs_sense dut_u (.core_clk_i(core_clk), .arst_n_i(arst_n), .codec_source_select_i(sel),
    .rx_line_i(rx_line), .collision_pair_pos_i(pair_pos), .collision_pair_neg_i(pair_neg),
    .carrier_sense_in_i(codec_source_select.carrier), .collision_in_i(codec_source_select.collision), .tx_sfd_start_i(sfd),
    .tx_active_i(tx_act), .carrier_sense_out_o(crs_pin), .carrier_sense_oe_o(crs_oe),
    .collision_out_o(col_pin), .collision_oe_o(col_oe), .mac_carrier_sense_o(mac_crs),
    .mac_collision_o(mac_col), .tx_collision_o(tx_col), .heartbeat_seen_o(hb_seen),
    .heartbeat_missing_o(hb_miss));
  ccs_far_end far_u (.core_clk_i(core_clk), .rx_line_o(rx_line), .pair_pos_o(pair_pos),
    .pair_neg_o(pair_neg), .ext_o(codec_source_select));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Lands just after an edge, where inputs are driven and outputs settled
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // Select only moves under reset since it is a strap
  task automatic do_reset(input logic s);
    arst_n = 1'b0;
    sel = s;
    tick(6);
    chk("outputs in reset", 1'b0, |{crs_pin, crs_oe, col_pin, col_oe, mac_crs, mac_col, tx_col, hb_seen, hb_miss});
    arst_n = 1'b1;
    tick(4);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    $display("watchdog expired");
    test_done();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    sfd = 1'b0;
    tx_act = 1'b0;
    foreach (rows[i]) begin
      do_reset(rows[i].sel);
      far_u.ext_set(rows[i].codec_source_select);
      tick(5);
      chk("mac_carrier_sense_o", rows[i].mac.carrier, mac_crs);
      chk("mac_collision_o", rows[i].mac.collision, mac_col);
      chk("carrier_sense_oe_o", rows[i].oe, crs_oe);
      chk("collision_oe_o", rows[i].oe, col_oe);
      far_u.ext_set(ccs_pkg::SENSE_RST);
    end
    $display("select table done");
    do_reset(1'b0);
    far_u.rx_burst(1);
    tick(3);
    chk("carrier early", 1'b0, mac_crs);
    tick(1);
    chk("mac_carrier_sense_o", 1'b1, mac_crs);
    chk("carrier_sense_out_o", 1'b1, crs_pin);
    far_u.rx_burst(8);
    tick(11);
    chk("carrier tail", 1'b1, crs_pin);
    tick(1);
    chk("carrier end", 1'b0, crs_pin);
    far_u.rx_burst(1);
    tick(6);
    chk("rising start", 1'b0, mac_crs);
    far_u.pair_burst(8);
    chk("collision_out_o", 1'b1, col_pin);
    chk("mac_collision_o", 1'b1, mac_col);
    tick(14);
    chk("collision end", 1'b0, col_pin);
    $display("on-chip codec done");
    do_reset(1'b1);
    sfd = 1'b1;
    tick(1);
    sfd = 1'b0;
    tx_act = 1'b1;
    far_u.ext_set(2'h1);
    tick(6);
    chk("tx_collision_o", 1'b1, tx_col);
    far_u.ext_set(ccs_pkg::SENSE_RST);
    // Let the frame collision drain through the synchroniser so it is not taken as heartbeat
    tick(3);
    tx_act = 1'b0;
    tick(10);
    chk("heartbeat_seen_o early", 1'b0, hb_seen);
    far_u.ext_set(2'h1);
    tick(6);
    chk("heartbeat_seen_o", 1'b1, hb_seen);
    far_u.ext_set(ccs_pkg::SENSE_RST);
    tick(170);
    sfd = 1'b1;
    tick(1);
    sfd = 1'b0;
    tx_act = 1'b1;
    tick(2);
    chk("tx_collision_o cleared", 1'b0, tx_col);
    chk("heartbeat_seen_o cleared", 1'b0, hb_seen);
    tick(10);
    tx_act = 1'b0;
    tick(int'(ccs_pkg::HB_WINDOW_CYC));
    chk("heartbeat_missing_o early", 1'b0, hb_miss);
    tick(1);
    chk("heartbeat_missing_o", 1'b1, hb_miss);
    tick(1);
    chk("heartbeat_missing_o pulse", 1'b0, hb_miss);
    far_u.ext_set(2'h1);
    tick(6);
    chk("idle collision", 1'b0, tx_col);
    $display("transmit watch done");
    test_done();
  end
endmodule
`default_nettype wire
